// >>> opm_checker.sv
// timing checks on the otp program memory port
module opm_checker
	import opm_pkg::*;
(
	input wire logic       CLK_SYS,
	input wire logic       RST_N,
	input wire logic       PROG_MODE_REQ,
	input wire logic       PROG_DISABLE_FUSE,
	input wire logic       OSC_IN_PIN,
	input wire logic       PORT3_LINE1,
	input wire logic [1:0] PORT3_LINE2,
	input wire logic       PORT0_LINE0,
	input wire logic       PORT0_LINE1,
	input wire logic       MEMORY_DATA_BUS_OE_N,
	input wire logic       PROG_MODE_ACTIVE,
	input wire logic [8:0] PROG_ADDR,
	input wire logic       IN_VECTOR_AREA
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	// ****
	// properties
	// ****
	chk_clear_hold: assert property (PORT0_LINE0[*2] |=> PROG_ADDR == OPM_ADDR_RST)
		else $error("address not held at zero");
	// clear pipeline is two deep; steps are only judged three cycles clear of it
	chk_step_one: assert property ($changed(PROG_ADDR) && !$past(PORT0_LINE0) && !$past(PORT0_LINE0, 2)
		&& !$past(PORT0_LINE0, 3) |-> PROG_ADDR == $past(PROG_ADDR) + 9'h001)
		else $error("address moved by other than one");
	chk_cs_block: assert property (OSC_IN_PIN && !PORT0_LINE0 && $rose(PORT0_LINE1) |=> $stable(PROG_ADDR)[*3])
		else $error("address moved while deselected");
	chk_drive_bus: assert property (!OSC_IN_PIN && PROG_MODE_ACTIVE && !PORT3_LINE1
		&& PORT3_LINE2 == OPM_OP_READ |=> !MEMORY_DATA_BUS_OE_N)
		else $error("bus not driven on read");
	chk_release_bus: assert property (PORT3_LINE1 |=> MEMORY_DATA_BUS_OE_N)
		else $error("bus not released");
	chk_fuse_block: assert property (PROG_DISABLE_FUSE[*2] |=> !PROG_MODE_ACTIVE)
		else $error("mode entered with fuse set");
	chk_mode_entry: assert property (PROG_MODE_REQ && !PROG_DISABLE_FUSE |-> ##2 PROG_MODE_ACTIVE)
		else $error("mode not entered");
	chk_vec_area: assert property ($past(RST_N) && $stable(PROG_ADDR)
		|-> IN_VECTOR_AREA == (PROG_ADDR < OPM_VEC_BYTES))
		else $error("vector flag wrong");
endmodule : opm_checker

// >>> opm_mem.sv
// one-time-programmable byte array with registered read data
module opm_mem #(
	parameter int DEPTH = 512,
	parameter int AW    = 9,
	parameter int DW    = 8
) (
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] addr,
	input  wire logic [DW-1:0] wdata,
	output logic      [DW-1:0] rdata
);
	logic [DW-1:0] mem [DEPTH];
	logic [DEPTH-1:0] burnt_q;

	// fuses only clear bits between resets; reset clears burnt_q, so a burn after reset can raise a bit
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[addr] <= burnt_q[addr] ? (mem[addr] & wdata) : wdata;
		end
		rdata <= burnt_q[addr] ? mem[addr] : {DW{1'b1}};
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			burnt_q <= '0;
		end else if (wr_en) begin
			burnt_q[addr] <= 1'b1;
		end
	end
endmodule : opm_mem

// >>> opm_pkg.sv
// package of constants and carriers for the otp program memory port
package opm_pkg;
	localparam int          OPM_DEPTH      = 512;
	localparam int          OPM_AW         = 9;
	localparam int          OPM_DW         = 8;
	localparam logic [8:0]  OPM_ADDR_RST   = 9'h000;
	localparam logic [8:0]  OPM_ADDR_LAST  = 9'h1ff;
	localparam logic [8:0]  OPM_VEC_BYTES  = 9'h00c;
	localparam logic [7:0]  OPM_ERASED     = 8'hff;
	localparam logic [1:0]  OPM_OP_RST     = 2'h0;

	// programmer-side control levels after pin remap
	typedef struct packed {
		logic chip_sel_n;
		logic read_drive_n;
		logic [1:0] memory_op_select;
		logic prog_supply;
		logic addr_clear;
		logic addr_clock;
		logic write_pulse_n;
	} opm_ctrl_s;

	typedef enum logic [1:0] {
		OPM_OP_READ   = 2'b00,
		OPM_OP_PROG   = 2'b01,
		OPM_OP_VERIFY = 2'b10,
		OPM_OP_NONE   = 2'b11
	} opm_op_e;
endpackage : opm_pkg

// >>> opm_port.sv
// programming and read-back port of the otp program memory
//
// Notes on behaviour
// R1: high address clear holds counter at zero
// R2: each address clock advances counter by one; code counts only while chip select is low in programming mode
// R3: read drive low drives bus, high releases; code drives only while the operation is read or verify
// R4: programmer toggles read drive per byte read
// R5: low write pulse programs bus byte
// R6: chip select low gates read, program, verify
// R7: eight-line bidirectional data bus
// R8: pins remap in programming mode
// R9: programmer picks operation via mode select
// R10: 512 byte locations, addresses 0 to 511
// R11: lowest 12 bytes hold interrupt vectors
// R12: disable option blocks programming and test entry
// R13: nine-bit counter wraps after 511
module opm_port
	import opm_pkg::*;
#(
	parameter int DEPTH = OPM_DEPTH,
	parameter int AW    = OPM_AW,
	parameter int DW    = OPM_DW
) (
	input  wire logic          CLK_SYS,
	input  wire logic          RST_N,
	input  wire logic          PROG_MODE_REQ,
	input  wire logic          PROG_DISABLE_FUSE,
	input  wire logic          OSC_IN_PIN,
	input  wire logic          OSC_OUT_PIN,
	input  wire logic          PORT3_LINE1,
	input  wire logic [1:0]    PORT3_LINE2,
	input  wire logic          PORT3_LINE3,
	input  wire logic          PORT0_LINE0,
	input  wire logic          PORT0_LINE1,
	input  wire logic          PORT0_LINE2,
	input  wire logic [DW-1:0] MEMORY_DATA_BUS_I,
	output logic      [DW-1:0] MEMORY_DATA_BUS_O,
	output logic               MEMORY_DATA_BUS_OE_N,
	output logic               PROG_MODE_ACTIVE,
	output logic [AW-1:0]      PROG_ADDR,
	output logic               IN_VECTOR_AREA
);
	import opm_pkg::*;

	// ****************************************
	// pin remap
	// ****************************************
	opm_ctrl_s ctrl;
	// osc_out_pin has no function in this mode
	assign ctrl.chip_sel_n       = OSC_IN_PIN;        // R8
	assign ctrl.read_drive_n     = PORT3_LINE1;       // R8
	assign ctrl.memory_op_select = PORT3_LINE2;       // R8
	assign ctrl.prog_supply      = PORT3_LINE3;       // R8
	assign ctrl.addr_clear       = PORT0_LINE0;       // R8
	assign ctrl.addr_clock       = PORT0_LINE1;       // R8
	assign ctrl.write_pulse_n    = PORT0_LINE2;       // R8

	// ****************************************
	// mode entry
	// ****************************************
	logic mode_q;
	wire  mode_d = PROG_MODE_REQ & ~PROG_DISABLE_FUSE; // R12
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) mode_q <= 1'b0;
		else        mode_q <= mode_d;
	end

	// ****************************************
	// address counter
	// ****************************************
	logic [AW-1:0] addr_q;
	logic          clk_q;
	logic          wp_q;
	wire           sel       = mode_q & ~ctrl.chip_sel_n;                 // R6
	wire           clk_rise  = ctrl.addr_clock & ~clk_q;
	wire [AW-1:0]  addr_inc  = (addr_q == AW'(DEPTH - 1)) ? '0 : addr_q + 1'b1; // R13 R10
	wire [AW-1:0]  addr_d    = ctrl.addr_clear ? OPM_ADDR_RST :             // R1
	                           (sel && clk_rise) ? addr_inc : addr_q;        // R2 R6
	opm_op_e       op;
	assign op = opm_op_e'(ctrl.memory_op_select);                          // R9

	// one burn per write-pulse falling edge; holding it low does not re-burn
	wire wp_fall = ~ctrl.write_pulse_n & wp_q;
	wire wr_en   = sel & wp_fall & (op == OPM_OP_PROG) & ctrl.prog_supply; // R5
	// only read and verify put the device on the bus; "none" leaves it released
	wire op_rd   = (op == OPM_OP_READ) | (op == OPM_OP_VERIFY);            // R9
	wire drive   = sel & ~ctrl.read_drive_n & op_rd;                       // R3 R7

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			addr_q <= OPM_ADDR_RST;
			clk_q  <= 1'b0;
			wp_q   <= 1'b1;
		end else begin
			addr_q <= addr_d;
			clk_q  <= ctrl.addr_clock;
			wp_q   <= ctrl.write_pulse_n;
		end
	end

	// ****************************************
	// storage
	// ****************************************
	logic [DW-1:0] rdata;
	opm_mem #(.DEPTH(DEPTH), .AW(AW), .DW(DW)) u_mem (
		.clk   (CLK_SYS),
		.rst_n (RST_N),
		.wr_en (wr_en),
		.addr  (addr_q),
		.wdata (MEMORY_DATA_BUS_I),
		.rdata (rdata)
	);

	// ****************************************
	// outputs
	// ****************************************
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			MEMORY_DATA_BUS_O    <= OPM_ERASED;
			MEMORY_DATA_BUS_OE_N <= 1'b1;
			PROG_MODE_ACTIVE     <= 1'b0;
			PROG_ADDR            <= OPM_ADDR_RST;
			IN_VECTOR_AREA       <= 1'b0;
		end else begin
			MEMORY_DATA_BUS_O    <= rdata;                  // R7
			MEMORY_DATA_BUS_OE_N <= ~drive;                 // R3
			PROG_MODE_ACTIVE     <= mode_q;
			PROG_ADDR            <= addr_q;
			IN_VECTOR_AREA       <= addr_q < OPM_VEC_BYTES; // R11
		end
	end
endmodule : opm_port

// >>> opm_prog_model.sv
// programmer-side bus resolver for the otp port
module opm_prog_model (
	input  wire logic       dev_oe_n,
	input  wire logic [7:0] dev_data,
	input  wire logic [7:0] host_data,
	output logic      [7:0] bus_i
);
	timeunit 1ns;
	timeprecision 1ns;
	// programmer drives only once the device lets go, so no contention
	assign bus_i = dev_oe_n ? host_data : dev_data;
endmodule : opm_prog_model

// >>> tb_top.sv
// self-checking bench for the otp program memory port
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin n_errors++; $display("BAD %s exp %h got %h", n, e, s); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import opm_pkg::*;
	logic clk = 0, rst_n = 0, req = 0, fuse = 0;
	opm_ctrl_s c = 8'hf1;
	logic [7:0] hd = 8'h00;
	wire [7:0] bi, bo;
	wire [8:0] pa;
	wire oe_n, act, vec;
	int n_errors = 0, tests_run = 0;
	always #10 clk = ~clk;
	opm_port dut (.CLK_SYS(clk), .RST_N(rst_n), .PROG_MODE_REQ(req), .PROG_DISABLE_FUSE(fuse),
		.OSC_IN_PIN(c.chip_sel_n), .OSC_OUT_PIN(1'b0), .PORT3_LINE1(c.read_drive_n), .PORT3_LINE2(c.memory_op_select),
		.PORT3_LINE3(c.prog_supply), .PORT0_LINE0(c.addr_clear), .PORT0_LINE1(c.addr_clock),
		.PORT0_LINE2(c.write_pulse_n), .MEMORY_DATA_BUS_I(bi), .MEMORY_DATA_BUS_O(bo),
		.MEMORY_DATA_BUS_OE_N(oe_n), .PROG_MODE_ACTIVE(act), .PROG_ADDR(pa), .IN_VECTOR_AREA(vec));
	opm_prog_model pm (.dev_oe_n(oe_n), .dev_data(bo), .host_data(hd), .bus_i(bi));
	// ****
	// tasks
	// ****
	task automatic w(input int n); repeat (n) @(negedge clk); endtask : w
	task automatic pulse(); c.addr_clock = 1; w(2); c.addr_clock = 0; w(2); endtask : pulse
	task automatic clr(); c.addr_clear = 1; w(2); c.addr_clear = 0; w(2); endtask : clr
	task automatic t_mode();
		fuse = 1; req = 1; w(3); `CHK("mode", 1'b0, act)
		fuse = 0; w(2); `CHK("mode", 1'b1, act)
		c.chip_sel_n = 0;
	endtask : t_mode
	task automatic t_burn();
		c.memory_op_select = OPM_OP_PROG; c.prog_supply = 1; clr(); hd = 8'h5a;
		c.write_pulse_n = 0; w(2); c.write_pulse_n = 1; w(2); pulse(); `CHK("addr", 9'h001, pa)
		c.chip_sel_n = 1; pulse(); `CHK("addr", 9'h001, pa)
		c.chip_sel_n = 0; clr(); `CHK("addr", 9'h000, pa)
		c.memory_op_select = OPM_OP_READ; c.read_drive_n = 0; w(4); `CHK("oe", 1'b0, oe_n)
		`CHK("data", 8'h5a, bo)
		c.read_drive_n = 1; w(2); `CHK("oe", 1'b1, oe_n)
		pulse(); c.read_drive_n = 0; w(4); `CHK("data", OPM_ERASED, bo)
		c.memory_op_select = OPM_OP_NONE; w(2); `CHK("oe", 1'b1, oe_n)
		c.memory_op_select = OPM_OP_VERIFY; w(2); `CHK("oe", 1'b0, oe_n)
		c.memory_op_select = OPM_OP_READ;
	endtask : t_burn
	task automatic t_wrap();
		clr(); repeat (11) pulse(); `CHK("vec", 1'b1, vec)
		pulse(); `CHK("vec", 1'b0, vec)
		repeat (500) pulse(); `CHK("addr", 9'h000, pa)
	endtask : t_wrap
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : tally_and_finish
	initial begin
		#100us;
		n_errors++;
		tally_and_finish();
	end
	initial begin
		w(6); rst_n = 1; w(1);
		`CHK("oe", 1'b1, oe_n)
		`CHK("addr", 9'h000, pa)
		t_mode(); t_burn(); t_wrap(); tally_and_finish();
	end
endmodule : tb_top
bind opm_port opm_checker chk (.*);
